//--- pkg/enc_pkg.sv
// Functional notes
// - shift correctly at link rates above about 33 kHz up to 2 MHz
// - word is 14-bit angle plus 24-bit turns
// - preset input loads zero or factory value
// - preset position readable about 1 ms later
// - preset commit takes 200 ms afterwards
// - direction high makes counterclockwise count up
// - direction change reaches position within 1 ms
// - no valid position for 150 ms after power-up
// - burst inside monoflop resends same latched word
`default_nettype none
package enc_pkg;

  // ----------------------------------------------------------------
  // clock and word layout
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int ANGLE_MAX = 14;
  localparam int TURNS_MAX = 24;
  localparam int LINK_MAX_KHZ = 2000;

  // ----------------------------------------------------------------
  // timing figures and their cycle counts
  // ----------------------------------------------------------------
  localparam int SET_DELAY_MS = 1;
  localparam int SET_DELAY_CYC = SET_DELAY_MS * 1000 * CYC_PER_US;
  localparam int COMMIT_MS = 200;
  localparam int COMMIT_CYC = COMMIT_MS * 1000 * CYC_PER_US;
  localparam int POWERUP_MS = 150;
  localparam int POWERUP_CYC = POWERUP_MS * 1000 * CYC_PER_US;
  localparam int MONOFLOP_US = 15;
  localparam int MONOFLOP_CYC = MONOFLOP_US * CYC_PER_US;
  // three sampling flops plus edge compare must fit in half a link period
  localparam int LINK_HALF_CYC = (CLK_HZ / 1000) / (2 * LINK_MAX_KHZ);

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [TURNS_MAX-1:0] revolution_count_part;
    logic [ANGLE_MAX-1:0] single_revolution_part;
  } position_s;

  typedef struct packed {
    logic link_clk;
    logic preset;
    logic direction;
  } pins_s;

  localparam pins_s PINS_IDLE = '{link_clk: 1'b1, preset: 1'b0, direction: 1'b0};

  typedef enum logic [2:0] {
    SSI_IDLE  = 3'b001,
    SSI_SHIFT = 3'b010,
    SSI_MONO  = 3'b100
  } ssi_state_e;

endpackage
`default_nettype wire

//--- hw/pin_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sampler #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk, // block clock
  input wire logic reset, // async, active high
  input wire logic [WIDTH-1:0] async_in, // pins from outside the domain
  output logic [WIDTH-1:0] level // accepted level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  wire logic [WIDTH-1:0] agree = ~(stage2 ^ stage3);
  wire logic [WIDTH-1:0] next_level = (agree & stage3) | (~agree & level);

  // stage1 feeds only stage2; a bit is accepted once stage2 and stage3 match
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      level <= next_level;
    end
  end

endmodule // pin_sampler
`default_nettype wire

//--- hw/ssi_multiturn_position_encoder.sv
`timescale 1ns/1ps
`default_nettype none
module ssi_multiturn_position_encoder
  import enc_pkg::*;
#(
  parameter int ANGLE_BITS = ANGLE_MAX,
  parameter int TURNS_BITS = TURNS_MAX,
  parameter logic [ANGLE_MAX+TURNS_MAX-1:0] PRESET_VALUE = '0, // factory preset
  parameter bit DIR_INVERT = 1'b0, // factory count sense inversion
  parameter bit GRAY_CODE = 1'b0, // gray instead of binary on the link
  parameter int unsigned SET_DELAY = SET_DELAY_CYC,
  parameter int unsigned COMMIT_TIME = COMMIT_CYC,
  parameter int unsigned POWERUP_TIME = POWERUP_CYC
) (
  input wire logic clk, // 25 MHz block clock
  input wire logic reset, // async, active high
  input wire logic ssi_clk, // link clock from controller, idles high
  input wire logic preset_pin, // preset request, active high
  input wire logic direction_pin, // high: ccw counts up
  input wire position_s sensor_pos, // raw absolute shaft position
  output logic ssi_data, // serial position data
  output position_s position, // reported position
  output logic position_valid, // power-up delay over
  output logic commit_busy // preset commit in progress
);

  localparam int W = ANGLE_BITS + TURNS_BITS;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // both parts need at least one bit, since each is sliced from the sensor word
  if (ANGLE_BITS < 1 || ANGLE_BITS > ANGLE_MAX ||
      TURNS_BITS < 1 || TURNS_BITS > TURNS_MAX) begin : g_bad_width
    $error("word widths out of range");
  end
  if (LINK_HALF_CYC < 4) begin : g_bad_rate
    $error("block clock too slow for link rate");
  end
  if (SET_DELAY < 1 || COMMIT_TIME < 1 || POWERUP_TIME < 1) begin : g_bad_time
    $error("timing counts must be at least one");
  end

  function automatic logic [W-1:0] to_gray(input logic [W-1:0] bin);
    to_gray = bin ^ (bin >> 1);
  endfunction

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  pins_s pins_raw;
  pins_s pins;
  assign pins_raw = '{link_clk: ssi_clk, preset: preset_pin, direction: direction_pin};

  pin_sampler #(
    .WIDTH($bits(pins_s)),
    .RESET_VAL(PINS_IDLE)
  ) u_pins (
    .clk(clk),
    .reset(reset),
    .async_in(pins_raw),
    .level(pins)
  );

  logic link_prev;
  wire logic link_fall = link_prev & ~pins.link_clk;
  wire logic link_rise = ~link_prev & pins.link_clk;
  wire logic link_edge = link_fall | link_rise;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_prev <= 1'b1;
    end else begin
      link_prev <= pins.link_clk;
    end
  end

  // ----------------------------------------------------------------
  // power-up delay
  // ----------------------------------------------------------------
  logic [31:0] power_cnt;
  wire logic power_done = (power_cnt >= POWERUP_TIME);

  // data is held invalid until the counter runs out; reset restarts it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_cnt <= '0;
      position_valid <= 1'b0;
    end else begin
      if (!power_done) power_cnt <= power_cnt + 32'h00000001;
      position_valid <= power_done;
    end
  end

  // ----------------------------------------------------------------
  // preset handling
  // ----------------------------------------------------------------
  logic [31:0] set_cnt;
  logic [31:0] commit_cnt;
  logic [W-1:0] ref_pos;
  logic [W-1:0] base_pos;
  wire logic [W-1:0] raw_pos = {sensor_pos.revolution_count_part[TURNS_BITS-1:0],
                                sensor_pos.single_revolution_part[ANGLE_BITS-1:0]};
  // fires once per press, after the input has stood high for the input delay
  wire logic set_fire = pins.preset && (set_cnt == SET_DELAY - 1);

  // a short press never reaches the delay and is dropped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      set_cnt <= '0;
    end else if (!pins.preset) begin
      set_cnt <= '0;
    end else if (set_cnt < SET_DELAY) begin
      set_cnt <= set_cnt + 32'h00000001;
    end
  end

  // the position at the press becomes the new reference for the preset value
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ref_pos <= '0;
      base_pos <= '0;
    end else if (set_fire) begin
      ref_pos <= raw_pos;
      base_pos <= PRESET_VALUE[W-1:0];
    end
  end

  // commit runs on its own; a new press during it restarts the commit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      commit_cnt <= '0;
      commit_busy <= 1'b0;
    end else if (set_fire) begin
      commit_cnt <= COMMIT_TIME - 1;
      commit_busy <= 1'b1;
    end else if (commit_cnt != '0) begin
      commit_cnt <= commit_cnt - 32'h00000001;
    end else begin
      commit_busy <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // direction and reported position
  // ----------------------------------------------------------------
  wire logic count_ccw = pins.direction ^ DIR_INVERT;
  wire logic [W-1:0] delta = count_ccw ? (ref_pos - raw_pos) : (raw_pos - ref_pos);
  wire logic [W-1:0] next_pos = base_pos + delta;
  wire logic [ANGLE_MAX+TURNS_MAX-1:0] next_wide = (ANGLE_MAX+TURNS_MAX)'(next_pos);

  // refreshed every cycle, so a direction change lands a few cycles after the pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      position <= '0;
    end else begin
      position.revolution_count_part <= '0;
      position.single_revolution_part <= '0;
      position.single_revolution_part[ANGLE_BITS-1:0] <= next_pos[ANGLE_BITS-1:0];
      position.revolution_count_part[TURNS_BITS-1:0] <= next_wide[W-1:ANGLE_BITS];
    end
  end

  // ----------------------------------------------------------------
  // serial readout
  // ----------------------------------------------------------------
  ssi_state_e state;
  ssi_state_e next_state;
  logic [W-1:0] latch_word;
  logic [W-1:0] shift_word;
  logic [5:0] bits_left;
  logic [31:0] mono_cnt;
  wire logic [W-1:0] pos_word = position_valid ? next_wide[W-1:0] : '0;
  wire logic [W-1:0] fresh_word = GRAY_CODE ? to_gray(pos_word) : pos_word;
  wire logic mono_out = (mono_cnt >= MONOFLOP_CYC);
  wire logic start_fresh = (state == SSI_IDLE) && link_fall;
  wire logic start_again = (state == SSI_MONO) && link_fall && !mono_out;
  wire logic shift_bit = (state == SSI_SHIFT) && link_rise && (bits_left != 6'h00);
  wire logic end_word = (state == SSI_SHIFT) && link_rise && (bits_left == 6'h00);
  wire logic time_out = (state != SSI_IDLE) && mono_out && !link_edge;

  // a quiet link also ends a burst cut short by the controller
  always_comb begin
    next_state = state;
    unique case (state)
      SSI_IDLE: if (start_fresh) next_state = SSI_SHIFT;
      SSI_SHIFT: begin
        if (time_out) next_state = SSI_IDLE;
        else if (end_word) next_state = SSI_MONO;
      end
      SSI_MONO: begin
        if (start_again) next_state = SSI_SHIFT;
        else if (time_out) next_state = SSI_IDLE;
      end
      default: next_state = SSI_IDLE;
    endcase
  end

  // monoflop restarts on every link edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= SSI_IDLE;
      mono_cnt <= '0;
    end else begin
      state <= next_state;
      if (link_edge) mono_cnt <= '0;
      else if (!mono_out) mono_cnt <= mono_cnt + 32'h00000001;
    end
  end

  // word is latched on the first falling edge and shifted on rising edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_word <= '0;
      shift_word <= '0;
      bits_left <= '0;
      ssi_data <= 1'b1;
    end else if (start_fresh) begin
      latch_word <= fresh_word;
      shift_word <= fresh_word;
      bits_left <= 6'(W);
    end else if (start_again) begin
      shift_word <= latch_word;
      bits_left <= 6'(W);
    end else if (shift_bit) begin
      ssi_data <= shift_word[W-1];
      shift_word <= shift_word << 1;
      bits_left <= bits_left - 6'h01;
    end else if (end_word) begin
      ssi_data <= 1'b0; // low through the monoflop time
    end else if (time_out) begin
      ssi_data <= 1'b1;
    end
  end

endmodule // ssi_multiturn_position_encoder
`default_nettype wire

//--- dv/enc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// encoder port checker
// ----------------------------------------------------------------
module enc_chk
  import enc_pkg::*;
#(
  parameter int unsigned SET_DELAY = 8,
  parameter int unsigned COMMIT_TIME = 20,
  parameter int unsigned POWERUP_TIME = 16,
  parameter logic [ANGLE_MAX+TURNS_MAX-1:0] PRESET_VALUE = '0
) (
  input wire logic clk, // block clock
  input wire logic reset, // async, active high
  input wire logic ssi_clk, // link clock
  input wire logic preset_pin, // preset request
  input wire logic ssi_data, // serial data
  input wire position_s position, // reported position
  input wire logic position_valid, // power-up over
  input wire logic commit_busy // preset commit running
);
  int unsigned quiet;
  int unsigned busy_n;
  int unsigned up_n;

  // link high time, commit length and time since reset; the first and last saturate, commit length clears when commit_busy drops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quiet <= 0;
      busy_n <= 0;
      up_n <= 0;
    end else begin
      quiet <= ssi_clk ? (quiet < 1000 ? quiet + 1 : quiet) : 0;
      busy_n <= commit_busy ? busy_n + 1 : 0;
      up_n <= (up_n < POWERUP_TIME) ? up_n + 1 : up_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_valid_late: assert property (position_valid |-> up_n >= POWERUP_TIME)
    else $error("position valid too early");
  a_valid_holds: assert property (position_valid |=> position_valid)
    else $error("position valid dropped");
  a_preset_load: assert property ($rose(commit_busy) |-> ##[0:1] position == PRESET_VALUE)
    else $error("preset value not loaded");
  a_preset_held: assert property ($rose(commit_busy) |-> $past(preset_pin, SET_DELAY))
    else $error("preset taken after a short press");
  a_commit_len: assert property ($fell(commit_busy) |-> busy_n == COMMIT_TIME)
    else $error("commit length wrong");
  a_commit_max: assert property (busy_n <= COMMIT_TIME)
    else $error("commit runs too long");
  a_idle_high: assert property (quiet > 400 |-> ssi_data)
    else $error("data not high while idle");
  a_burst_start: assert property ($fell(ssi_clk) && quiet > 400 |-> ssi_data [*8])
    else $error("data left high level before first rise");
endmodule // enc_chk

bind ssi_multiturn_position_encoder enc_chk #(
  .SET_DELAY(SET_DELAY), .COMMIT_TIME(COMMIT_TIME), .POWERUP_TIME(POWERUP_TIME),
  .PRESET_VALUE(PRESET_VALUE)
) enc_chk_i (
  .clk(clk), .reset(reset), .ssi_clk(ssi_clk), .preset_pin(preset_pin), .ssi_data(ssi_data),
  .position(position), .position_valid(position_valid), .commit_busy(commit_busy)
);
`default_nettype wire

//--- dv/ssi_master.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// link controller model
// ----------------------------------------------------------------
module ssi_master (
  input wire logic clk, // block clock, paces the link
  input wire logic ssi_data, // serial data from the encoder
  output logic ssi_clk // link clock, still and high between frames
);
  // four block clocks a half period give 160 ns, a 320 ns period, faster than the 2 MHz rate allowed
  task automatic half();
    repeat (4) @(negedge clk);
  endtask

  // fall latches, each later rise but the last shifts; a bit is taken just before the next rise
  task automatic read(output logic [37:0] w);
    half();
    ssi_clk = 1'b0;
    half();
    ssi_clk = 1'b1;
    for (int i = 37; i >= 0; i--) begin
      half();
      ssi_clk = 1'b0;
      half();
      w[i] = ssi_data;
      ssi_clk = 1'b1;
    end
  endtask

  initial ssi_clk = 1'b1;
endmodule // ssi_master
`default_nettype wire

//--- dv/ssi_multiturn_position_encoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// encoder bench
// ----------------------------------------------------------------
module ssi_multiturn_position_encoder_tb_top;
  import enc_pkg::*;
  localparam int unsigned SD = 8;
  localparam int unsigned CT = 20;
  localparam int unsigned PT = 16;
  logic clk, reset, ssi_clk, preset_pin, direction_pin, ssi_data, position_valid, commit_busy;
  position_s sensor_pos, position;
  logic [37:0] w;
  localparam logic [37:0] PV2 = 38'h00_0000_0100;
  logic ssi_clk2, ssi_data2;
  position_s position2;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  ssi_multiturn_position_encoder #(.SET_DELAY(SD), .COMMIT_TIME(CT), .POWERUP_TIME(PT))
    ssi_multiturn_position_encoder_i (.clk(clk), .reset(reset), .ssi_clk(ssi_clk),
    .preset_pin(preset_pin), .direction_pin(direction_pin), .sensor_pos(sensor_pos),
    .ssi_data(ssi_data), .position(position), .position_valid(position_valid),
    .commit_busy(commit_busy));
  ssi_master ssi_master_i (.clk(clk), .ssi_data(ssi_data), .ssi_clk(ssi_clk));

  // second build with the factory options: own preset value, inverted sense, gray link code
  ssi_multiturn_position_encoder #(.PRESET_VALUE(PV2), .DIR_INVERT(1'b1), .GRAY_CODE(1'b1),
    .SET_DELAY(SD), .COMMIT_TIME(CT), .POWERUP_TIME(PT))
    ssi_multiturn_position_encoder_f_i (.clk(clk), .reset(reset), .ssi_clk(ssi_clk2),
    .preset_pin(preset_pin), .direction_pin(direction_pin), .sensor_pos(sensor_pos),
    .ssi_data(ssi_data2), .position(position2), .position_valid(), .commit_busy());
  ssi_master ssi_master_f_i (.clk(clk), .ssi_data(ssi_data2), .ssi_clk(ssi_clk2));

  // 40 ns block clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      results();
    end
  end

  task automatic chkw(string s, logic [37:0] x, logic [37:0] g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic chkb(string s, logic x, logic g);
    n_checks++;
    if (g !== x) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", s, x, g);
    end
  endtask

  // let the 15 us monoflop run out so the next frame is fresh
  task automatic idle(int n = 400);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_power();
    repeat (3) @(negedge clk);
    chkb("data in reset", 1'b1, ssi_data);
    chkb("valid in reset", 1'b0, position_valid);
    reset = 1'b0;
    ssi_master_i.read(w);
    chkw("early word", 38'h0, w);
    chkb("valid later", 1'b1, position_valid);
    $display("power-up test done");
  endtask

  task automatic t_read();
    idle();
    chkb("idle data", 1'b1, ssi_data);
    chkw("position", 38'h12_3456_789A, position);
    ssi_master_i.read(w);
    chkw("word", 38'h12_3456_789A, w);
    idle(8);
    chkb("monoflop data", 1'b0, ssi_data);
    $display("read test done");
  endtask

  task automatic t_mono();
    sensor_pos = 38'h12_3456_789B;
    ssi_master_i.read(w);
    chkw("repeat word", 38'h12_3456_789A, w);
    idle();
    ssi_master_i.read(w);
    chkw("fresh word", 38'h12_3456_789B, w);
    $display("monoflop test done");
  endtask

  task automatic t_preset();
    idle();
    preset_pin = 1'b1;
    idle(SD - 4);
    preset_pin = 1'b0;
    idle(20);
    chkb("short press", 1'b0, commit_busy);
    preset_pin = 1'b1;
    for (int i = 0; i < 40 && commit_busy !== 1'b1; i++) @(negedge clk);
    chkb("commit start", 1'b1, commit_busy);
    idle(2);
    chkw("preset pos", 38'h0, position);
    idle(3 * SD);
    preset_pin = 1'b0;
    idle(CT);
    chkb("commit end", 1'b0, commit_busy);
    sensor_pos = 38'h12_3456_78A0;
    idle(4);
    chkw("moved pos", 38'h5, position);
    idle();
    ssi_master_i.read(w);
    chkw("moved word", 38'h5, w);
    $display("preset test done");
  endtask

  task automatic t_dir();
    direction_pin = 1'b1;
    idle(12);
    chkw("ccw pos", 38'h3F_FFFF_FFFB, position);
    sensor_pos = 38'h12_3456_78A3;
    idle(4);
    chkw("ccw move", 38'h3F_FFFF_FFF8, position);
    idle();
    ssi_master_i.read(w);
    chkw("ccw word", 38'h3F_FFFF_FFF8, w);
    direction_pin = 1'b0;
    idle(12);
    chkw("cw again", 38'h8, position);
    $display("direction test done");
  endtask

  // the factory build took the same press at 9B; now at A3 with inverted sense it is 100 - 8
  task automatic t_factory();
    chkw("factory pos", 38'hF8, position2);
    ssi_master_f_i.read(w);
    chkw("gray word", 38'h84, w);
    direction_pin = 1'b1;
    idle(12);
    chkw("factory cw", 38'h108, position2);
    direction_pin = 1'b0;
    $display("factory options test done");
  endtask

  // reset held three cycles, then each scenario in turn
  initial begin
    reset = 1'b1;
    preset_pin = 1'b0;
    direction_pin = 1'b0;
    sensor_pos = 38'h12_3456_789A;
    t_power();
    t_read();
    t_mono();
    t_preset();
    t_dir();
    t_factory();
    results();
  end
endmodule // ssi_multiturn_position_encoder_tb_top
`default_nettype wire
